// ### src/p9gpio_port.sv
// port 9 general purpose pins shared with serial interface and external interrupt four
`timescale 1ns/1ps
module p9gpio_port import p9gpio_pkg::*; (
	input wire logic clock_i, // system clock, 50 MHz
	input wire logic nrst_i, // async reset, active low
	input wire logic hw_standby_i, // hardware standby, acts like reset
	input wire logic sw_standby_i, // software standby, registers hold
	input wire p9gpio_bus_t bus_i, // register port request
	output logic [7:0] rdata_o, // read data, cycle after read strobe
	input wire p9gpio_sercfg_t sercfg_i, // serial interface pin controls
	input wire logic txd_i, // serial transmit data to drive on pin 0
	input wire logic sck_out_i, // serial clock to drive on pin 4
	output logic rxd_o, // serial receive data from pin 2
	output logic sck_in_o, // serial clock from pin 4
	output logic ext_interrupt_four_o, // pin 4 level to interrupt logic
	input wire logic [2:0] pin_i, // pin levels {p4,p2,p0}
	output logic [2:0] pin_o, // pin drive values {p4,p2,p0}
	output logic [2:0] pin_oe_o // pin output enables {p4,p2,p0}
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] dat;
		logic [7:0] rdata;
		logic [2:0] pin;
		logic [2:0] oe;
		logic rxd;
		logic sck_in;
		logic ext_interrupt_four;
	} p9gpio_state_t;

	p9gpio_state_t st_r, st_nxt;
	logic [2:0] pin_s;
	logic [7:0] pin_byte;
	logic [2:0] gen_dir;
	logic [2:0] gen_dat;

	// maps the three compact pins onto their byte positions
	function automatic logic [7:0] spread(input logic [2:0] v);
		logic [7:0] b;
		b = 8'h00;
		b[P9_CLK_BIT] = v[2];
		b[P9_RXD_BIT] = v[1];
		b[P9_TXD_BIT] = v[0];
		return b;
	endfunction

	p9gpio_sync #(
		.W(3)
	) u_sync (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.d_i(pin_i),
		.q_o(pin_s)
	);

	assign pin_byte = spread(pin_s);
	assign gen_dir = {st_r.dir[P9_CLK_BIT], st_r.dir[P9_RXD_BIT], st_r.dir[P9_TXD_BIT]};
	assign gen_dat = {st_r.dat[P9_CLK_BIT], st_r.dat[P9_RXD_BIT], st_r.dat[P9_TXD_BIT]};

	// ****************************************************************
	// next state
	// ****************************************************************
	// no operating mode input exists: the sharing is identical in all modes
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = 8'h00;
		if (hw_standby_i) begin
			st_nxt.dir = P9_DIR_RST;
			st_nxt.dat = P9_DAT_RST;
		end else if (!sw_standby_i) begin
			// software standby blocks register writes so contents and drive persist
			if (bus_i.wr && bus_i.addr == P9_DIR_OFS) begin
				st_nxt.dir = bus_i.wdata;
			end
			if (bus_i.wr && bus_i.addr == P9_DAT_OFS) begin
				st_nxt.dat = bus_i.wdata | P9_DAT_FIXED;
			end
			if (bus_i.rd && bus_i.addr == P9_DIR_OFS) begin
				st_nxt.rdata = P9_RD_ONES;
			end
			if (bus_i.rd && bus_i.addr == P9_DAT_OFS) begin
				// only real pin bits follow the pin when input
				st_nxt.rdata = (st_r.dat & ~(~st_r.dir & P9_PIN_MASK)) |
					(pin_byte & ~st_r.dir & P9_PIN_MASK);
			end
		end

		// pin 4: serial clock, then general port
		if (sercfg_i.clock_enable_high) begin
			st_nxt.oe[2] = 1'b0;
			st_nxt.pin[2] = 1'b0;
		end else if (sercfg_i.sync_select || sercfg_i.clock_enable_low) begin
			st_nxt.oe[2] = 1'b1;
			st_nxt.pin[2] = sck_out_i;
		end else begin
			st_nxt.oe[2] = gen_dir[2];
			st_nxt.pin[2] = gen_dat[2];
		end
		// pin 2: receive data or general port
		if (sercfg_i.receive_enable_bit) begin
			st_nxt.oe[1] = 1'b0;
			st_nxt.pin[1] = 1'b0;
		end else begin
			st_nxt.oe[1] = gen_dir[1];
			st_nxt.pin[1] = gen_dat[1];
		end
		// pin 0: transmit data or general port
		if (sercfg_i.transmit_enable_bit) begin
			st_nxt.oe[0] = 1'b1;
			st_nxt.pin[0] = txd_i;
		end else begin
			st_nxt.oe[0] = gen_dir[0];
			st_nxt.pin[0] = gen_dat[0];
		end
		st_nxt.rxd = pin_s[1];
		st_nxt.sck_in = pin_s[2];
		st_nxt.ext_interrupt_four = pin_s[2];
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r.dir <= P9_DIR_RST;
			st_r.dat <= P9_DAT_RST;
			st_r.rdata <= 8'h00;
			st_r.pin <= 3'h0;
			st_r.oe <= 3'h0;
			st_r.rxd <= 1'b0;
			st_r.sck_in <= 1'b0;
			st_r.ext_interrupt_four <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// three physical pins only
	assign pin_o = st_r.pin;
	assign pin_oe_o = st_r.oe;
	assign rdata_o = st_r.rdata;
	assign rxd_o = st_r.rxd;
	assign sck_in_o = st_r.sck_in;
	assign ext_interrupt_four_o = st_r.ext_interrupt_four;

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence dir_rd_s;
		bus_i.rd && bus_i.addr == P9_DIR_OFS && !sw_standby_i && !hw_standby_i;
	endsequence

	sequence dat_wr_s;
		bus_i.wr && bus_i.addr == P9_DAT_OFS && !sw_standby_i && !hw_standby_i;
	endsequence

	dir_read_ones_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		dir_rd_s |=> rdata_o == 8'hff)
		else $error("direction read not all ones");

	dat_fixed_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		dat_wr_s |=> st_r.dat[7:6] == 2'b11)
		else $error("data bits 7 and 6 not one");

	dat_store_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		dat_wr_s |=> st_r.dat[5:0] == $past(bus_i.wdata[5:0]))
		else $error("data write not stored");

	hw_standby_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		hw_standby_i |=> st_r.dir == 8'hc0 && st_r.dat == 8'hc0)
		else $error("hardware standby did not load reset values");

	sw_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		sw_standby_i && !hw_standby_i |=> $stable(st_r.dir) && $stable(st_r.dat))
		else $error("software standby changed registers");

	clk_input_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		sercfg_i.clock_enable_high |=> !pin_oe_o[2])
		else $error("pin 4 driven while clock input");

	gen_pin4_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!sercfg_i.clock_enable_high && !sercfg_i.clock_enable_low && !sercfg_i.sync_select
		|=> pin_oe_o[2] == $past(st_r.dir[4]))
		else $error("pin 4 general direction wrong");

	txd_drive_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		sercfg_i.transmit_enable_bit |=> pin_oe_o[0] && pin_o[0] == $past(txd_i))
		else $error("transmit data not driven");

	rxd_input_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		sercfg_i.receive_enable_bit |=> !pin_oe_o[1])
		else $error("pin 2 driven while receiving");

	irq_follow_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		ext_interrupt_four_o == $past(pin_s[2]) || !$past(nrst_i))
		else $error("interrupt input not following pin 4");

	sequence dat_rd_s;
		bus_i.rd && bus_i.addr == P9_DAT_OFS && !sw_standby_i && !hw_standby_i;
	endsequence

	sequence dir_wr_s;
		bus_i.wr && bus_i.addr == P9_DIR_OFS && !sw_standby_i && !hw_standby_i;
	endsequence

	// output pins read back the latch, not the pin, so a loaded pin cannot fool software
	rd_latch_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		dat_rd_s |=> (rdata_o & $past(st_r.dir) & P9_PIN_MASK) ==
		($past(st_r.dat) & $past(st_r.dir) & P9_PIN_MASK))
		else $error("output pin read not from latch");

	rd_pin_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		dat_rd_s |=> (rdata_o & ~$past(st_r.dir) & P9_PIN_MASK) ==
		($past(pin_byte) & ~$past(st_r.dir) & P9_PIN_MASK))
		else $error("input pin read not from pin");

	rd_fixed_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		dat_rd_s |=> rdata_o[7:6] == 2'b11)
		else $error("data read bits 7 and 6 not one");

	dir_store_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		dir_wr_s |=> st_r.dir == $past(bus_i.wdata))
		else $error("direction write not stored");

	gen_pin0_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!sercfg_i.transmit_enable_bit |=> pin_oe_o[0] == $past(st_r.dir[0]))
		else $error("pin 0 general direction wrong");

	gen_pin2_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!sercfg_i.receive_enable_bit |=> pin_oe_o[1] == $past(st_r.dir[2]))
		else $error("pin 2 general direction wrong");

	clk_output_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!sercfg_i.clock_enable_high && (sercfg_i.sync_select || sercfg_i.clock_enable_low)
		|=> pin_oe_o[2] && pin_o[2] == $past(sck_out_i))
		else $error("serial clock not driven on pin 4");
endmodule

// ### shared/p9gpio_pkg.sv
// package with register map, reset values, field positions and carrier types of the port 9 block
// ****************************************************************
// Overview of operation
// - three real pins at bits 4, 2 and 0, each input or output.
// - pin functions are the same in every chip operating mode.
// - direction bit 1 drives the pin, 0 leaves it an input.
// - direction register is write-only and reads back all ones.
// - reset and hardware standby load direction register with c0.
// - software standby keeps direction contents, outputs keep driving.
// - data read gives pin level on bits 4, 2 and 0 where direction is 0, else latch.
// - data bits 7 and 6 ignore writes and read as one.
// - data bits 5, 3 and 1 are plain storage without pins.
// - reset and hardware standby load data register with c0; soft standby keeps.
// - pin 4 is clock input if high enable, else clock output per select/low enable.
// - pin 4 is general port only when both enables and select are zero.
// - pin 4 level always feeds external interrupt four input.
// - pin 0 drives transmit data when transmit enable set, else general port.
// ****************************************************************
package p9gpio_pkg;
	localparam logic [15:0] P9_DIR_OFS = 16'hffd0;
	localparam logic [15:0] P9_DAT_OFS = 16'hffd2;
	localparam logic [7:0] P9_DIR_RST = 8'hc0;
	localparam logic [7:0] P9_DAT_RST = 8'hc0;
	localparam logic [7:0] P9_DAT_FIXED = 8'hc0;
	localparam logic [7:0] P9_PIN_MASK = 8'h15;
	localparam logic [7:0] P9_RD_ONES = 8'hff;
	localparam int P9_CLK_BIT = 4;
	localparam int P9_RXD_BIT = 2;
	localparam int P9_TXD_BIT = 0;

	// serial interface controls that steer the pin sharing
	typedef struct packed {
		logic clock_enable_high;
		logic clock_enable_low;
		logic sync_select;
		logic receive_enable_bit;
		logic transmit_enable_bit;
	} p9gpio_sercfg_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} p9gpio_bus_t;
endpackage

// ### src/p9gpio_sync.sv
// three-stage synchroniser for the pin inputs with agreement filter
`timescale 1ns/1ps
module p9gpio_sync import p9gpio_pkg::*; #(
	parameter int W = 3
) (
	input wire logic clock_i, // system clock
	input wire logic nrst_i, // async reset, active low
	input wire logic [W-1:0] d_i, // raw pin levels
	output logic [W-1:0] q_o // filtered levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} p9gpio_sync_t;
	p9gpio_sync_t st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// a change is taken only once stages two and three agree
		for (int i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.q;
endmodule

// ### sim/p9gpio_board.sv
// board-side model of the three port pins
`timescale 1ns/1ps
module p9gpio_board (
	input wire logic [2:0] pin_o, // port drive values
	input wire logic [2:0] pin_oe_o, // port drive enables
	input wire logic [2:0] ext_i, // levels the board drives
	output logic [2:0] pin_i // resolved pin levels
);
	// the board yields wherever the port drives, so no contention is modelled
	assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
endmodule

// ### sim/p9gpio_port_tb.sv
// self-checking testbench for the port 9 pin block
`timescale 1ns/1ps
module p9gpio_port_tb;
	import p9gpio_pkg::*;
	logic clock_i = 0, nrst_i = 0, hws = 0, sws = 0, txd = 0, sck = 0;
	p9gpio_bus_t bus = '0;
	p9gpio_sercfg_t cfg = '0;
	logic [7:0] rdata, dir, lat, rd;
	logic [2:0] pin_o, pin_oe, pin_i, ext = 3'h5;
	logic rxd, sckin, irq;
	int n_fail = 0, n_compared = 0, seed = 32'h7a17, cyc = 0, i;
	always #10 clock_i = ~clock_i;
	p9gpio_port u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .hw_standby_i(hws),
		.sw_standby_i(sws), .bus_i(bus), .rdata_o(rdata), .sercfg_i(cfg), .txd_i(txd),
		.sck_out_i(sck), .rxd_o(rxd), .sck_in_o(sckin), .ext_interrupt_four_o(irq),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe));
	p9gpio_board u_board (.pin_o(pin_o), .pin_oe_o(pin_oe), .ext_i(ext), .pin_i(pin_i));
	function automatic logic [7:0] exp_rd(input logic [7:0] d, l, input logic [2:0] p);
		logic [7:0] pv;
		pv = {3'h0, p[2], 1'b0, p[1], 1'b0, p[0]};
		return P9_DAT_FIXED | (l & d) | (pv & ~d & P9_PIN_MASK) | (l & ~P9_PIN_MASK);
	endfunction
	function automatic logic [7:0] exp_pin(input logic [7:0] d, l);
		logic [2:0] oe, o;
		oe[2] = !cfg.clock_enable_high && (cfg.sync_select || cfg.clock_enable_low || d[4]);
		o[2] = (cfg.sync_select || cfg.clock_enable_low) ? sck : l[4];
		oe[1] = !cfg.receive_enable_bit && d[2];
		o[1] = l[2];
		oe[0] = cfg.transmit_enable_bit || d[0];
		o[0] = cfg.transmit_enable_bit ? txd : l[0];
		return {2'b00, oe, o & oe};
	endfunction
	task automatic cmp(input logic [7:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_i) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_i) bus.wr <= 1'b0;
	endtask
	task automatic rdr(input logic [15:0] a);
		@(posedge clock_i) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock_i) bus.rd <= 1'b0;
		#1 rd = rdata;
	endtask
	// pin inputs pass a synchroniser, so let them settle before looking
	task automatic chk_pins;
		repeat (8) @(posedge clock_i);
		#1 cmp({2'b00, pin_oe, pin_o & pin_oe}, exp_pin(dir, lat));
		cmp({5'h0, irq, rxd | ~cfg.receive_enable_bit, sckin | ~cfg.clock_enable_high},
			{5'h0, pin_i[2], pin_i[1] | ~cfg.receive_enable_bit,
			pin_i[2] | ~cfg.clock_enable_high});
	endtask
	task automatic chk;
		chk_pins();
		rdr(P9_DAT_OFS);
		cmp(rd, exp_rd(dir, lat, pin_i));
	endtask
	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	// ****
	// main sequence
	// ****
	initial begin
		repeat (4) @(posedge clock_i);
		nrst_i <= 1'b1;
		dir = P9_DIR_RST;
		lat = P9_DAT_RST;
		chk();
		$display("reset values done");
		for (i = 0; i < 40; i++) begin
			dir = $random(seed);
			lat = $random(seed) | P9_DAT_FIXED;
			@(posedge clock_i);
			cfg <= (i % 2) ? p9gpio_sercfg_t'($random(seed)) : '0;
			{ext, txd, sck} <= $random(seed);
			wr(P9_DIR_OFS, dir);
			wr(P9_DAT_OFS, lat & 8'h3f);
			rdr(P9_DIR_OFS);
			cmp(rd, P9_RD_ONES);
			chk();
		end
		$display("random mix done");
		rdr(16'hffd1);
		cmp(rd, 8'h00);
		wr(16'hffd4, 8'h00);
		chk();
		$display("unmapped done");
		@(posedge clock_i) sws <= 1'b1;
		wr(P9_DIR_OFS, ~dir);
		wr(P9_DAT_OFS, ~lat);
		chk_pins();
		@(posedge clock_i) sws <= 1'b0;
		chk();
		$display("software standby done");
		@(posedge clock_i) hws <= 1'b1;
		repeat (2) @(posedge clock_i);
		hws <= 1'b0;
		dir = P9_DIR_RST;
		lat = P9_DAT_RST;
		chk();
		$display("hardware standby done");
		wr(P9_DIR_OFS, 8'h15);
		wr(P9_DAT_OFS, 8'h2a);
		@(posedge clock_i) nrst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'b1;
		dir = P9_DIR_RST;
		lat = P9_DAT_RST;
		chk();
		$display("mid-run reset done");
		final_report();
	end
endmodule
